// ===== sscw_defines.svh
`ifndef SSCW_DEFINES_SVH
`define SSCW_DEFINES_SVH

// Core clock rate in kHz (20 MHz)
`define SSCW_CLK_KHZ        20000

// Watchdog timeouts, nominal, in ms, by timeout field code
`define SSCW_WDTO0_MS       620
`define SSCW_WDTO1_MS       310
`define SSCW_WDTO2_MS       2500
`define SSCW_WDTO3_MS       1250
`define SSCW_WDTO0_CYC      (`SSCW_WDTO0_MS * `SSCW_CLK_KHZ)
`define SSCW_WDTO1_CYC      (`SSCW_WDTO1_MS * `SSCW_CLK_KHZ)
`define SSCW_WDTO2_CYC      (`SSCW_WDTO2_MS * `SSCW_CLK_KHZ)
`define SSCW_WDTO3_CYC      (`SSCW_WDTO3_MS * `SSCW_CLK_KHZ)

// Overcurrent blanking windows, nominal, in us
`define SSCW_OCH_US         10
`define SSCW_OCL0_US        155000
`define SSCW_OCL1_US        10000
`define SSCW_OCL2_US        1200
`define SSCW_OCL3_US        150
`define SSCW_OCH_CYC        (`SSCW_OCH_US * `SSCW_CLK_KHZ / 1000)
`define SSCW_OCL0_CYC       (`SSCW_OCL0_US * `SSCW_CLK_KHZ / 1000)
`define SSCW_OCL1_CYC       (`SSCW_OCL1_US * `SSCW_CLK_KHZ / 1000)
`define SSCW_OCL2_CYC       (`SSCW_OCL2_US * `SSCW_CLK_KHZ / 1000)
`define SSCW_OCL3_CYC       (`SSCW_OCL3_US * `SSCW_CLK_KHZ / 1000)

// Command word layout
`define SSCW_FRAME_BITS     4'h8
`define SSCW_CMD_TOGGLE     7
`define SSCW_CMD_ADDR_HI    6
`define SSCW_CMD_ADDR_LO    4
`define SSCW_CMD_DATA_HI    3

// Command addresses
`define SSCW_ADDR_OUT       3'h0
`define SSCW_ADDR_OCL       3'h1
`define SSCW_ADDR_OCH       3'h2
`define SSCW_ADDR_WDR       3'h3
`define SSCW_ADDR_RDSEL     3'h4

// Output control bits
`define SSCW_OUT_SPI_ON     0
`define SSCW_OUT_DIRECT_EN  1
`define SSCW_OUT_PWM_GROUP  2

// Watchdog configuration readback: failsafe flag position
`define SSCW_WDR_FS_BIT     2

`endif

// ===== sscw_pkg.sv
package sscw_pkg;

    typedef enum logic [1:0] {
        MODE_SLEEP,
        MODE_NORMAL,
        MODE_FAILSAFE
    } sscw_mode_t;

    typedef logic [7:0] sscw_byte_t;

endpackage

// ===== sscw_sync.sv
`timescale 1ns/10ps
`default_nettype none

module sscw_sync
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_r <= '0;
            stage2_r <= '0;
        end
        else
        begin
            stage1_r <= din;
            stage2_r <= stage1_r;
        end
    end

    assign dout = stage2_r;

endmodule // sscw_sync

`default_nettype wire

// ===== sscw_watchdog.sv
`timescale 1ns/10ps
`default_nettype none

module sscw_watchdog
#(
    parameter int unsigned T0 = 1,
    parameter int unsigned T1 = 1,
    parameter int unsigned T2 = 1,
    parameter int unsigned T3 = 1
)
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       enable,
    input  wire logic       kick,
    input  wire logic [1:0] sel,
    output logic            timeout
);

    logic [31:0] cnt_r;
    logic [31:0] cnt_nxt;
    logic [31:0] limit;
    logic        tmo_r;
    logic        tmo_nxt;

    always_comb
    begin
        case (sel)
            2'h0:    limit = T0;
            2'h1:    limit = T1;
            2'h2:    limit = T2;
            default: limit = T3;
        endcase
        cnt_nxt = cnt_r;
        tmo_nxt = 1'b0;
        if (!enable || kick)
        begin
            cnt_nxt = 32'h0;
        end
        else if (cnt_r >= limit - 32'h1)
        begin
            tmo_nxt = 1'b1;
            cnt_nxt = 32'h0;
        end
        else
        begin
            cnt_nxt = cnt_r + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_r <= 32'h0;
            tmo_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            tmo_r <= tmo_nxt;
        end
    end

    assign timeout = tmo_r;

endmodule // sscw_watchdog

`default_nettype wire

// ===== sscw_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sscw_defines.svh"

module sscw_top
    import sscw_pkg::*;
#(
    parameter int unsigned WDTO0_CYC = `SSCW_WDTO0_CYC,
    parameter int unsigned WDTO1_CYC = `SSCW_WDTO1_CYC,
    parameter int unsigned WDTO2_CYC = `SSCW_WDTO2_CYC,
    parameter int unsigned WDTO3_CYC = `SSCW_WDTO3_CYC,
    parameter int unsigned OCL0_CYC  = `SSCW_OCL0_CYC,
    parameter int unsigned OCL1_CYC  = `SSCW_OCL1_CYC,
    parameter int unsigned OCL2_CYC  = `SSCW_OCL2_CYC
)
(
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       csN,
    input  wire logic       sclk,
    input  wire logic       si,
    output logic            so,
    output logic            soOe,
    input  wire logic       wake,
    input  wire logic       deviceRstN,
    input  wire logic       directIn,
    input  wire logic       failsafeSelectGnd,
    input  wire logic       failsafeSelectOn,
    input  wire logic       logicSupplyOk,
    input  wire logic       openLoadFault,
    input  wire logic       overcurrentLowFault,
    input  wire logic       overcurrentHighFault,
    input  wire logic       thermalFault,
    input  wire logic       underVoltFault,
    input  wire logic       overVoltFault,
    output logic            faultFlagNOut,
    output logic            faultFlagNOe,
    output logic            hsOn,
    output logic            sleepMode,
    output logic            failsafeFlag,
    output logic [1:0]      oclBlankSel,
    output logic [1:0]      oclThreshSel,
    output logic [1:0]      ochThreshSel,
    output logic            ochBlankActive,
    output logic            oclBlankActive
);

    localparam int unsigned OCH_CYC  = `SSCW_OCH_CYC;
    localparam int unsigned OCL3_CYC = `SSCW_OCL3_CYC;

    logic [14:0] syncOut;
    logic        csS, sclkS, siS, wakeS, rstS, dirS, fsiGndS, fsiOnS, vddOkS;
    logic        csInvS;
    logic [5:0]  faultRaw;

    // Every pin passes two flip-flops before any logic looks at it
    // Chip select goes through inverted, so a cleared synchroniser reads deselected
    sscw_sync #(.W(15)) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  ({~csN, sclk, si, wake, deviceRstN, directIn, failsafeSelectGnd, failsafeSelectOn,
                logicSupplyOk, thermalFault, overVoltFault, underVoltFault, openLoadFault,
                overcurrentHighFault, overcurrentLowFault}),
        .dout (syncOut)
    );

    assign {csInvS, sclkS, siS, wakeS, rstS, dirS, fsiGndS, fsiOnS, vddOkS} = syncOut[14:6];
    assign csS = !csInvS;
    assign faultRaw = syncOut[5:0];

    sscw_mode_t  mode_r, mode_nxt;
    sscw_byte_t  shift_r, shift_nxt;
    logic [3:0]  bitCnt_r, bitCnt_nxt;
    logic        csPrev_r, sclkPrev_r, wakePrev_r, rstPrev_r;
    logic [2:0]  outCtl_r, outCtl_nxt;
    logic [3:0]  ocl_r, ocl_nxt;
    logic [1:0]  och_r, och_nxt;
    logic [1:0]  wdSel_r, wdSel_nxt;
    logic [2:0]  rdSel_r, rdSel_nxt;
    logic        lastToggle_r, lastToggle_nxt;
    logic        wdArmed_r, wdArmed_nxt;
    logic [5:0]  faultLat_r, faultLat_nxt;
    logic        fsOe_r, fsOe_nxt;
    logic        hsOn_r, hsOn_nxt;
    logic [31:0] onCnt_r, onCnt_nxt;

    logic        sclkRise, csFall, csRise, frameOk, armEdge, kick, wdTimeout;
    logic        cfgClear, sleepCond, ochWin, oclWin;
    logic [31:0] oclLimit;
    logic [5:0]  faultQual;
    sscw_byte_t  rdWord, cmd;

    assign sclkRise  = sclkS && !sclkPrev_r;
    assign csFall    = !csS && csPrev_r;
    assign csRise    = csS && !csPrev_r;
    assign frameOk   = csRise && (bitCnt_r == `SSCW_FRAME_BITS);
    assign cmd       = shift_r;
    assign cfgClear  = !rstS || !vddOkS;
    assign sleepCond = !rstS && !wakeS;
    assign armEdge   = (wakeS && !wakePrev_r) || (rstS && !rstPrev_r);
    // A new toggle value on bit seven of a complete frame restarts the timer
    assign kick      = armEdge || (frameOk && (cmd[`SSCW_CMD_TOGGLE] != lastToggle_r));

    sscw_watchdog #(
        .T0 (WDTO0_CYC),
        .T1 (WDTO1_CYC),
        .T2 (WDTO2_CYC),
        .T3 (WDTO3_CYC)
    ) u_wdog (
        .clk     (clk),
        .nrst    (nrst),
        .enable  (wdArmed_r && (mode_r == MODE_NORMAL)),
        .kick    (kick),
        .sel     (wdSel_r),
        .timeout (wdTimeout)
    );

    // Blanking windows measured from output turn-on
    always_comb
    begin
        case (ocl_r[1:0])
            2'h0:    oclLimit = OCL0_CYC;
            2'h1:    oclLimit = OCL1_CYC;
            2'h2:    oclLimit = OCL2_CYC;
            default: oclLimit = OCL3_CYC;
        endcase
    end

    assign ochWin    = hsOn_r && (onCnt_r < OCH_CYC);
    assign oclWin    = hsOn_r && (onCnt_r < oclLimit);
    assign faultQual = {faultRaw[5:2], faultRaw[1] && !ochWin, faultRaw[0] && !oclWin};

    always_comb
    begin
        case (rdSel_r)
            `SSCW_ADDR_OCL: rdWord = {4'h0, ocl_r};
            `SSCW_ADDR_OCH: rdWord = {6'h0, och_r};
            `SSCW_ADDR_WDR: rdWord = {5'h0, mode_r == MODE_FAILSAFE, wdSel_r};
            `SSCW_ADDR_OUT: rdWord = {5'h0, outCtl_r};
            default:        rdWord = {faultLat_r, mode_r == MODE_FAILSAFE, fsOe_r};
        endcase
    end

    always_comb
    begin
        shift_nxt  = shift_r;
        bitCnt_nxt = bitCnt_r;
        if (csFall)
        begin
            shift_nxt  = rdWord;
            bitCnt_nxt = 4'h0;
        end
        else if (!csS && sclkRise)
        begin
            // Received bits follow the reply out, so a daisy chain passes commands on
            shift_nxt  = {shift_r[6:0], siS};
            bitCnt_nxt = (bitCnt_r > `SSCW_FRAME_BITS) ? bitCnt_r : bitCnt_r + 4'h1;
        end
    end

    always_comb
    begin
        outCtl_nxt     = outCtl_r;
        ocl_nxt        = ocl_r;
        och_nxt        = och_r;
        wdSel_nxt      = wdSel_r;
        rdSel_nxt      = rdSel_r;
        lastToggle_nxt = lastToggle_r;
        if (frameOk)
        begin
            lastToggle_nxt = cmd[`SSCW_CMD_TOGGLE];
            case (cmd[`SSCW_CMD_ADDR_HI:`SSCW_CMD_ADDR_LO])
                `SSCW_ADDR_OUT:   outCtl_nxt = cmd[2:0];
                `SSCW_ADDR_OCL:   ocl_nxt    = cmd[`SSCW_CMD_DATA_HI:0];
                `SSCW_ADDR_OCH:   och_nxt    = cmd[1:0];
                `SSCW_ADDR_WDR:   wdSel_nxt  = cmd[1:0];
                `SSCW_ADDR_RDSEL: rdSel_nxt  = cmd[2:0];
                default:          rdSel_nxt  = rdSel_r;
            endcase
        end
        if (mode_r == MODE_FAILSAFE)
        begin
            ocl_nxt = 4'h0;
            och_nxt = 2'h0;
        end
        if (cfgClear)
        begin
            outCtl_nxt     = 3'h0;
            ocl_nxt        = 4'h0;
            och_nxt        = 2'h0;
            wdSel_nxt      = 2'h0;
            rdSel_nxt      = 3'h0;
            lastToggle_nxt = 1'b0;
        end
    end

    always_comb
    begin
        // Set wins over the read clear
        faultLat_nxt = faultLat_r;
        // A completed frame that carried the status word clears what it reported
        if (frameOk && (rdSel_r >= `SSCW_ADDR_RDSEL))
        begin
            faultLat_nxt = 6'h00;
        end
        faultLat_nxt = faultLat_nxt | faultQual;
        if (cfgClear)
        begin
            faultLat_nxt = 6'h00;
        end
        fsOe_nxt = (|faultQual) || (|faultLat_r);
    end

    always_comb
    begin
        wdArmed_nxt = wdArmed_r;
        if (armEdge)
        begin
            wdArmed_nxt = 1'b1;
        end
        if (fsiGndS || sleepCond)
        begin
            wdArmed_nxt = 1'b0;
        end
        mode_nxt = mode_r;
        case (mode_r)
            MODE_SLEEP:
            begin
                if (!sleepCond)
                begin
                    mode_nxt = MODE_NORMAL;
                end
            end
            MODE_NORMAL:
            begin
                if (sleepCond)
                begin
                    mode_nxt = MODE_SLEEP;
                end
                else if (wdTimeout)
                begin
                    mode_nxt = MODE_FAILSAFE;
                end
            end
            MODE_FAILSAFE:
            begin
                if (sleepCond)
                begin
                    mode_nxt = MODE_SLEEP;
                end
                else if (fsiGndS)
                begin
                    mode_nxt = MODE_NORMAL;
                end
            end
            default: mode_nxt = MODE_SLEEP;
        endcase
    end

    always_comb
    begin
        if (mode_r == MODE_SLEEP)
        begin
            hsOn_nxt = 1'b0;
        end
        else if (!vddOkS)
        begin
            hsOn_nxt = dirS;
        end
        else if (mode_r == MODE_FAILSAFE)
        begin
            hsOn_nxt = fsiOnS || dirS;
        end
        else if (outCtl_r[`SSCW_OUT_DIRECT_EN])
        begin
            hsOn_nxt = dirS;
        end
        else if (outCtl_r[`SSCW_OUT_PWM_GROUP])
        begin
            hsOn_nxt = outCtl_r[`SSCW_OUT_SPI_ON] && dirS;
        end
        else
        begin
            hsOn_nxt = outCtl_r[`SSCW_OUT_SPI_ON];
        end
        onCnt_nxt = !hsOn_r ? 32'h0 : ((onCnt_r == 32'hFFFFFFFF) ? onCnt_r : onCnt_r + 32'h1);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mode_r       <= MODE_SLEEP;
            shift_r      <= 8'h00;
            bitCnt_r     <= 4'h0;
            csPrev_r     <= 1'b1;
            sclkPrev_r   <= 1'b0;
            wakePrev_r   <= 1'b0;
            rstPrev_r    <= 1'b0;
            outCtl_r     <= 3'h0;
            ocl_r        <= 4'h0;
            och_r        <= 2'h0;
            wdSel_r      <= 2'h0;
            rdSel_r      <= 3'h0;
            lastToggle_r <= 1'b0;
            wdArmed_r    <= 1'b0;
            faultLat_r   <= 6'h00;
            fsOe_r       <= 1'b0;
            hsOn_r       <= 1'b0;
            onCnt_r      <= 32'h0;
        end
        else
        begin
            mode_r       <= mode_nxt;
            shift_r      <= shift_nxt;
            bitCnt_r     <= bitCnt_nxt;
            csPrev_r     <= csS;
            sclkPrev_r   <= sclkS;
            wakePrev_r   <= wakeS;
            rstPrev_r    <= rstS;
            outCtl_r     <= outCtl_nxt;
            ocl_r        <= ocl_nxt;
            och_r        <= och_nxt;
            wdSel_r      <= wdSel_nxt;
            rdSel_r      <= rdSel_nxt;
            lastToggle_r <= lastToggle_nxt;
            wdArmed_r    <= wdArmed_nxt;
            faultLat_r   <= faultLat_nxt;
            fsOe_r       <= fsOe_nxt;
            hsOn_r       <= hsOn_nxt;
            onCnt_r      <= onCnt_nxt;
        end
    end

    assign so             = shift_r[7];
    assign soOe           = !csS;
    assign faultFlagNOut  = 1'b0;
    assign faultFlagNOe   = fsOe_r;
    assign hsOn           = hsOn_r;
    assign sleepMode      = (mode_r == MODE_SLEEP);
    assign failsafeFlag   = (mode_r == MODE_FAILSAFE);
    assign oclBlankSel    = ocl_r[1:0];
    assign oclThreshSel   = ocl_r[3:2];
    // Top threshold while the high window runs
    assign ochThreshSel   = ochWin ? 2'h0 : och_r;
    assign ochBlankActive = ochWin;
    assign oclBlankActive = oclWin;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // Enable follows the pin two clocks late, through the synchroniser
    property p_so_release;
        $past(csN, 2) |-> !soOe;
    endproperty
    a_so_release: assert property (p_so_release) else $error("serial output driven while deselected");

    property p_ignore_deselected;
        csS && $past(csS) |=> $stable(bitCnt_r);
    endproperty
    a_ignore_deselected: assert property (p_ignore_deselected) else $error("bit count moved while deselected");

    property p_shift_in;
        !csS && sclkRise && !csFall |=> shift_r[0] == $past(siS);
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("input bit not captured on rising clock");

    property p_shift_out;
        !csS && sclkRise && !csFall |=> so == $past(shift_r[6]);
    endproperty
    a_shift_out: assert property (p_shift_out) else $error("serial output did not advance");

    property p_short_frame;
        csRise && (bitCnt_r != `SSCW_FRAME_BITS) && rstS && vddOkS |=> $stable(outCtl_r) && $stable(wdSel_r);
    endproperty
    a_short_frame: assert property (p_short_frame) else $error("incomplete frame changed configuration");

    property p_fault_flag;
        |faultQual |=> faultFlagNOe ##1 1'b1;
    endproperty
    a_fault_flag: assert property (p_fault_flag) else $error("fault flag not pulled low");

    property p_timeout_failsafe;
        (mode_r == MODE_NORMAL) && wdTimeout && !sleepCond |=> failsafeFlag;
    endproperty
    a_timeout_failsafe: assert property (p_timeout_failsafe) else $error("timeout did not enter failsafe");

    property p_fsi_gnd;
        fsiGndS |=> !wdArmed_r ##1 (mode_r != MODE_FAILSAFE);
    endproperty
    a_fsi_gnd: assert property (p_fsi_gnd) else $error("grounded select left watchdog active");

    property p_reset_clears;
        !rstS |=> (outCtl_r == 3'h0) && (faultLat_r == 6'h00) && (wdSel_r == 2'h0);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset pin did not clear registers");

endmodule // sscw_top

`default_nettype wire

// ===== sscw_spi_master.sv
`timescale 1ns/10ps
`default_nettype none

module sscw_spi_master
    import sscw_pkg::*;
(
    output logic      csN,
    output logic      sclk,
    output logic      si,
    input  wire logic so
);
    initial
    begin
        csN  = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end

    // Frame of n bits, MSB first; n below 8 makes a deliberately short frame
    task automatic xfer(input sscw_byte_t tx, input int n, output sscw_byte_t rx);
        rx = '0;
        csN = 1'b0;
        #500;
        for (int i = 7; i > 7 - n; i--)
        begin
            si = tx[i];
            #200;
            rx[i] = so; // Taken while settled, just before the edge that advances it
            sclk = 1'b1;
            #200;
            sclk = 1'b0;
        end
        #200;
        csN = 1'b1;
        si = ~si; // Released line must not keep its last level
        #500;
    endtask
endmodule // sscw_spi_master

`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench
    import sscw_pkg::*;
();
    logic       clk;
    logic       nrst;
    logic       csN;
    logic       sclk;
    logic       si;
    logic       so;
    logic       soOe;
    logic       wake;
    logic       deviceRstN;
    logic       directIn;
    logic       fsGnd;
    logic       fsOn;
    logic [5:0] flt;
    logic       vddOk;
    logic       ffOut;
    logic       ochBlk;
    logic       oclBlk;
    logic       faultFlagNOe;
    logic       hsOn;
    logic       sleepMode;
    logic       failsafeFlag;
    logic       tog;
    logic [1:0] sel;
    sscw_byte_t rx;
    int         error_cnt;
    int         checks_done;
    int         cyc;

    sscw_top #(.WDTO0_CYC(200), .WDTO1_CYC(100), .WDTO2_CYC(800), .WDTO3_CYC(400),
               .OCL0_CYC(4000), .OCL1_CYC(1000), .OCL2_CYC(500)) DUT (
        .clk(clk), .nrst(nrst), .csN(csN), .sclk(sclk), .si(si), .so(so), .soOe(soOe),
        .wake(wake), .deviceRstN(deviceRstN), .directIn(directIn),
        .failsafeSelectGnd(fsGnd), .failsafeSelectOn(fsOn), .logicSupplyOk(vddOk),
        .openLoadFault(flt[0]), .overcurrentLowFault(flt[4]), .overcurrentHighFault(flt[5]),
        .thermalFault(flt[3]), .underVoltFault(flt[1]), .overVoltFault(flt[2]),
        .faultFlagNOut(ffOut), .faultFlagNOe(faultFlagNOe), .hsOn(hsOn), .sleepMode(sleepMode),
        .failsafeFlag(failsafeFlag), .oclBlankSel(), .oclThreshSel(), .ochThreshSel(),
        .ochBlankActive(ochBlk), .oclBlankActive(oclBlk));

    sscw_spi_master m (.csN(csN), .sclk(sclk), .si(si), .so(so));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 12000)
        begin
            error_cnt++;
            test_done();
        end
    end

    // Failsafe drive: forced on by the select resistor, else the parallel input
    function automatic logic exp_failsafe_out(input logic on, input logic din);
        return on | din;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    // Watchdog toggle bit flips only on frames that the device will accept
    task automatic send(input sscw_byte_t cmd, input int n);
        m.xfer({tog, cmd[6:0]}, n, rx);
        if (n == 8)
            tog = ~tog;
        @(negedge clk);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'h3a654d5c));
        {nrst, wake, deviceRstN, directIn, fsGnd, fsOn} = '0;
        // First accepted frame must differ from the cleared toggle history
        tog = 1'b1;
        vddOk = 1'b1;
        flt = '0;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        repeat (5) @(negedge clk);
        chk(soOe, 1'b0, "so driven while deselected");
        chk(sleepMode, 1'b1, "not asleep after reset");
        deviceRstN = 1'b1; // Supply already good
        wake = 1'b1;
        repeat (5) @(negedge clk);
        chk(sleepMode, 1'b0, "not in normal mode");
        send(8'h01, 8);
        chk(hsOn, 1'b1, "serial switch-on lost");
        send(8'h00, 7);
        chk(hsOn, 1'b1, "short frame acted on");
        send(8'h02, 8);
        for (int k = 0; k < 4; k++)
        begin
            directIn = 1'($urandom);
            repeat (6) @(negedge clk);
            chk(hsOn, directIn, "direct input not followed");
        end
        send(8'h05, 8);
        directIn = 1'b1;
        repeat (6) @(negedge clk);
        chk(hsOn, 1'b1, "grouped load not passed");
        directIn = 1'b0;
        repeat (6) @(negedge clk);
        chk(hsOn, 1'b0, "grouped load not gated");
        sel = 2'($urandom);
        send({4'h3, 2'b00, sel}, 8);
        send(8'h43, 8);
        send(8'h50, 8);
        chk(rx, {6'h00, sel}, "timeout field readback");
        send(8'h30, 8);
        for (int k = 0; k < 3; k++)
            send(8'h50, 8);
        chk(failsafeFlag, 1'b0, "failsafe despite toggling");
        fsOn = 1'($urandom);
        directIn = 1'($urandom);
        repeat (260) @(negedge clk);
        chk(failsafeFlag, 1'b1, "no failsafe after timeout");
        chk(hsOn, exp_failsafe_out(fsOn, directIn), "failsafe output");
        send(8'h50, 8);
        chk(rx[2], 1'b1, "failsafe flag not read");
        wake = 1'b0;
        deviceRstN = 1'b0;
        repeat (6) @(negedge clk);
        chk(sleepMode, 1'b1, "failsafe not left");
        fsGnd = 1'b1;
        wake = 1'b1;
        deviceRstN = 1'b1;
        repeat (300) @(negedge clk);
        chk(failsafeFlag, 1'b0, "watchdog ran while grounded");
        send(8'h44, 8);
        for (int k = 0; k < 4; k++)
        begin
            flt = 6'(1 << k);
            repeat (6) @(negedge clk);
            chk(faultFlagNOe, 1'b1, "fault flag not pulled low");
            send(8'h50, 8);
            chk(rx[4 + k], 1'b1, "fault not reported");
            flt = '0;
        end
        send(8'h50, 8);
        chk(faultFlagNOe, 1'b0, "fault flag stuck after status read");
        chk(ffOut, 1'b0, "fault flag data not low");
        send(8'h01, 8);
        directIn = 1'b0;
        vddOk = 1'b0;
        repeat (6) @(negedge clk);
        chk(hsOn, 1'b0, "supply loss: direct input low ignored");
        directIn = 1'b1;
        repeat (6) @(negedge clk);
        chk(hsOn, 1'b1, "supply loss: direct input high ignored");
        vddOk = 1'b1;
        repeat (6) @(negedge clk);
        chk(hsOn, 1'b0, "configuration kept over supply loss");
        send(8'h12, 8);
        send(8'h01, 8);
        flt = 6'h30;
        repeat (6) @(negedge clk);
        chk({ochBlk, oclBlk, faultFlagNOe}, 3'b110, "overcurrent not blanked after turn-on");
        repeat (250) @(negedge clk);
        chk({ochBlk, oclBlk, faultFlagNOe}, 3'b011, "high window not closed");
        repeat (300) @(negedge clk);
        chk(oclBlk, 1'b0, "low window not closed");
        test_done();
    end
endmodule // testbench

`default_nettype wire
